/* File: include/pbpwc_pkg.sv */
// Purpose: constants shared by the panel and window control block
// Assumes: 125 MHz core clock, 20-bit host memory address
// Notes:   display values are two hex digits, upper digit blanked when zero
// Function
// - The window base is segment D000h plus 200h per base-switch position, up to DE00h at position 7.
// - The host window spans 8 KB from the base and only accesses inside it are answered.
// - The two-digit display shows 1 while running and 0 while stopped.
// - Any error code on the display blinks instead of standing steady.
// - The run/stop switch left runs the controller and right halts it.
// - The boot-mode switch is sampled at start-up: left gives controller mode, right file-transfer mode.
// - In controller mode, moving the boot-mode switch right stores the program, shows blinking 80, then steady 0 stopped until run/stop goes right then left.
// - A mode change only takes effect by a reboot after reset, and file-transfer mode exposes the drives.
// - The reset key resets the controller processor.
// - On power fail outside file-transfer mode the retentive data are saved first and only then is the backup supply switched off.
// - With the backup supply unit fitted, the reload key reloads the program from flash into SRAM.
// - The intensity LED is on for high optical intensity and dark for reduced intensity.
// - Booting in controller mode with no program loaded shows a blinking error code.
package pbpwc_pkg;

    // ****************************************
    // shared memory window
    // ****************************************
    localparam logic [15:0] WIN_BASE_SEG   = 16'hD000;
    localparam logic [15:0] WIN_STEP_SEG   = 16'h0200;
    localparam int          WIN_SPAN_BYTES = 8192;
    localparam int          WIN_ADDR_LSB   = 13;

    // ****************************************
    // display values
    // ****************************************
    localparam logic [7:0] DISP_RUN   = 8'h01;
    localparam logic [7:0] DISP_STOP  = 8'h00;
    localparam logic [7:0] DISP_STORE = 8'h80;
    localparam logic [7:0] DISP_RESET = 8'h00;

    // ****************************************
    // timing
    // ****************************************
    localparam int CLK_MHZ        = 125;
    localparam int BLINK_HALF_MS  = 250;
    localparam int BLINK_HALF_CYC = BLINK_HALF_MS * CLK_MHZ * 1000;
    localparam int SETTLE_CYC     = 4;

    // ****************************************
    // controller states
    // ****************************************
    typedef enum logic [3:0] {
        ST_BOOT,
        ST_XFER,
        ST_NOPROG,
        ST_RUN,
        ST_STOP,
        ST_STORE,
        ST_RELOAD,
        ST_SAVE,
        ST_OFF
    } pbpwc_state_e;

endpackage

/* File: rtl/pbpwc_sync.sv */
// Purpose: three-stage synchroniser with agreement filter
// Assumes: inputs are asynchronous pins
// Notes:   output changes when stages two and three agree
`timescale 1ns/1ns
`default_nettype none
module pbpwc_sync #(
    parameter int W = 1
) (
    // clock and reset
    input  wire logic         core_clk_in,
    input  wire logic         rst_in,
    // pins
    input  wire logic [W-1:0] async_in,
    // filtered levels
    output logic      [W-1:0] level_out
);

    logic [W-1:0] s1_reg, s2_reg, s3_reg, lvl_reg;
    logic [W-1:0] lvl_next;

    always_comb begin
        lvl_next = lvl_reg;
        for (int i = 0; i < W; i++) begin
            if (s2_reg[i] == s3_reg[i]) begin
                lvl_next[i] = s3_reg[i];
            end
        end
    end

    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            s1_reg  <= '0;
            s2_reg  <= '0;
            s3_reg  <= '0;
            lvl_reg <= '0;
        end else begin
            s1_reg  <= async_in;
            s2_reg  <= s1_reg;
            s3_reg  <= s2_reg;
            lvl_reg <= lvl_next;
        end
    end

    assign level_out = lvl_reg;

endmodule
`default_nettype wire

/* File: rtl/pbpwc_top.sv */
// Purpose: front panel, boot mode and host window control
// Assumes: panel pins asynchronous; firmware handshakes on core clock
// Notes:   request outputs are levels held until the matching done
`timescale 1ns/1ns
`default_nettype none
module pbpwc_top
    import pbpwc_pkg::*;
#(
    parameter int          BLINK_CYC  = BLINK_HALF_CYC,
    parameter logic [7:0]  ERR_NOPROG = 8'hE1
) (
    // clock and reset
    input  wire logic        core_clk_in,
    input  wire logic        rst_in,
    // host expansion bus
    input  wire logic [19:0] host_addr_in,
    input  wire logic        host_memr_n_in,
    input  wire logic        host_memw_n_in,
    output logic             shm_sel_out,
    output logic             shm_data_oe_n_out,
    // panel switches and keys
    input  wire logic [2:0]  base_sw_in,
    input  wire logic        run_stop_sw_in,
    input  wire logic        boot_mode_sw_in,
    input  wire logic        reset_key_in,
    input  wire logic        reload_key_in,
    input  wire logic        intensity_sw_in,
    // backup supply unit
    input  wire logic        backup_supply_unit_fitted_in,
    input  wire logic        power_fail_in,
    output logic             backup_off_out,
    // controller firmware handshake
    input  wire logic        program_loaded_in,
    input  wire logic        store_done_in,
    input  wire logic        save_done_in,
    input  wire logic        reload_done_in,
    input  wire logic        error_valid_in,
    input  wire logic [7:0]  error_code_in,
    output logic             cpu_reset_out,
    output logic             ctrl_run_out,
    output logic             xfer_mode_out,
    output logic             store_req_out,
    output logic             save_req_out,
    output logic             reload_req_out,
    // indicators
    output logic [6:0]       digit_hi_out,
    output logic [6:0]       digit_lo_out,
    output logic             intensity_led_out
);

    // ****************************************
    // functions
    // ****************************************
    function automatic logic [6:0] seg7(input logic [3:0] v);
        logic [6:0] s;
        s = 7'h00;
        unique case (v)
            4'h0: s = 7'h3F;
            4'h1: s = 7'h06;
            4'h2: s = 7'h5B;
            4'h3: s = 7'h4F;
            4'h4: s = 7'h66;
            4'h5: s = 7'h6D;
            4'h6: s = 7'h7D;
            4'h7: s = 7'h07;
            4'h8: s = 7'h7F;
            4'h9: s = 7'h6F;
            4'hA: s = 7'h77;
            4'hB: s = 7'h7C;
            4'hC: s = 7'h39;
            4'hD: s = 7'h5E;
            4'hE: s = 7'h79;
            4'hF: s = 7'h71;
        endcase
        return s;
    endfunction

    function automatic logic in_window(input logic [19:0] a, input logic [2:0] sw);
        logic [19:0] base;
        base = {WIN_BASE_SEG + 16'(WIN_STEP_SEG * {13'h0000, sw}), 4'h0};
        return a[19:WIN_ADDR_LSB] == base[19:WIN_ADDR_LSB];
    endfunction

    // ****************************************
    // pin synchronisers
    // ****************************************
    logic [10:0] pins_f;
    logic [2:0]  base_f;
    logic        run_f, boot_f, rkey_f, lkey_f, int_f, pfail_f, memr_f, memw_f;

    // strobes enter inverted so the filter's reset level reads as idle
    pbpwc_sync #(.W(11)) u_sync (
        .core_clk_in (core_clk_in),
        .rst_in      (rst_in),
        .async_in    ({base_sw_in, run_stop_sw_in, boot_mode_sw_in, reset_key_in, reload_key_in,
                       intensity_sw_in, power_fail_in, !host_memr_n_in, !host_memw_n_in}),
        .level_out   (pins_f)
    );

    assign {base_f, run_f, boot_f, rkey_f, lkey_f, int_f, pfail_f, memr_f, memw_f} = pins_f;

    // ****************************************
    // host window decode
    // ****************************************
    logic [19:0] addr_reg, addr_next;
    logic        sel_reg, sel_next, oe_n_reg, oe_n_next;

    always_comb begin
        addr_next = host_addr_in;
        sel_next  = 1'b0;
        oe_n_next = 1'b1;
        if ((memr_f || memw_f) && in_window(addr_reg, base_f)) begin
            sel_next  = 1'b1;
            oe_n_next = !memr_f;
        end
    end

    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            addr_reg <= 20'h00000;
            sel_reg  <= 1'b0;
            oe_n_reg <= 1'b1;
        end else begin
            addr_reg <= addr_next;
            sel_reg  <= sel_next;
            oe_n_reg <= oe_n_next;
        end
    end

    // ****************************************
    // controller mode sequencing
    // ****************************************
    pbpwc_state_e st_reg, st_next;
    logic [2:0]   settle_reg, settle_next;
    logic         boot_d_reg, lkey_d_reg, hold_reg, hold_next, creset_reg, creset_next;
    logic         boot_rise, lkey_rise;

    assign boot_rise = boot_f && !boot_d_reg;
    assign lkey_rise = lkey_f && !lkey_d_reg;

    always_comb begin
        st_next     = st_reg;
        settle_next = settle_reg;
        // after a store, hold stop only while the run switch stays at run; it clears once the switch reads stop
        hold_next   = hold_reg && !run_f;
        creset_next = rkey_f;
        if (rkey_f) begin
            st_next     = ST_BOOT;
            settle_next = 3'd0;
            hold_next   = 1'b0;
        end else begin
            unique case (st_reg)
                ST_BOOT: begin
                    if (settle_reg != 3'(SETTLE_CYC)) begin
                        settle_next = settle_reg + 3'd1;
                    end else if (boot_f) begin
                        st_next = ST_XFER;
                    end else if (!program_loaded_in) begin
                        st_next = ST_NOPROG;
                    end else begin
                        st_next = run_f ? ST_STOP : ST_RUN;
                    end
                end
                ST_XFER: st_next = ST_XFER;
                ST_NOPROG, ST_RUN, ST_STOP: begin
                    if (boot_rise) begin
                        st_next = ST_STORE;
                    end else if (lkey_rise && backup_supply_unit_fitted_in) begin
                        st_next = ST_RELOAD;
                    end else if (st_reg == ST_NOPROG) begin
                        if (program_loaded_in) begin
                            st_next = ST_STOP;
                        end
                    end else begin
                        st_next = (run_f || hold_reg) ? ST_STOP : ST_RUN;
                    end
                end
                ST_STORE: begin
                    if (store_done_in) begin
                        st_next   = ST_STOP;
                        hold_next = 1'b1;
                    end
                end
                ST_RELOAD: begin
                    if (reload_done_in) begin
                        st_next = ST_STOP;
                    end
                end
                ST_SAVE: begin
                    if (save_done_in) begin
                        st_next = ST_OFF;
                    end
                end
                ST_OFF: st_next = ST_OFF;
                default: st_next = ST_BOOT;
            endcase
            if (pfail_f && st_reg != ST_SAVE && st_reg != ST_OFF && st_reg != ST_XFER) begin
                st_next = ST_SAVE;
            end
        end
    end

    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            st_reg     <= ST_BOOT;
            settle_reg <= 3'd0;
            boot_d_reg <= 1'b0;
            lkey_d_reg <= 1'b0;
            hold_reg   <= 1'b0;
            creset_reg <= 1'b1;
        end else begin
            st_reg     <= st_next;
            settle_reg <= settle_next;
            boot_d_reg <= boot_f;
            lkey_d_reg <= lkey_f;
            hold_reg   <= hold_next;
            creset_reg <= creset_next;
        end
    end

    // ****************************************
    // display and indicator outputs
    // ****************************************
    logic [31:0] blink_cnt_reg, blink_cnt_next;
    logic        blink_on_reg, blink_on_next;
    logic [6:0]  dhi_reg, dhi_next, dlo_reg, dlo_next;
    logic        run_reg, xfer_reg, store_reg, save_reg, reload_reg, off_reg, led_reg;
    logic [7:0]  disp_val;
    logic        disp_blink;

    always_comb begin
        disp_val   = DISP_STOP;
        disp_blink = 1'b0;
        unique case (st_next)
            ST_RUN:    disp_val = DISP_RUN;
            ST_STORE: begin
                disp_val   = DISP_STORE;
                disp_blink = 1'b1;
            end
            ST_NOPROG: begin
                disp_val   = ERR_NOPROG;
                disp_blink = 1'b1;
            end
            ST_BOOT:   disp_val = DISP_RESET;
            default:   disp_val = DISP_STOP;
        endcase
        if (error_valid_in && (st_next == ST_RUN || st_next == ST_STOP)) begin
            disp_val   = error_code_in;
            disp_blink = 1'b1;
        end
        if (blink_cnt_reg >= 32'(BLINK_CYC - 1)) begin
            blink_cnt_next = 32'd0;
            blink_on_next  = !blink_on_reg;
        end else begin
            blink_cnt_next = blink_cnt_reg + 32'd1;
            blink_on_next  = blink_on_reg;
        end
        dhi_next = (disp_val[7:4] == 4'h0) ? 7'h00 : seg7(disp_val[7:4]);
        dlo_next = seg7(disp_val[3:0]);
        if (disp_blink && !blink_on_reg) begin
            dhi_next = 7'h00;
            dlo_next = 7'h00;
        end
    end

    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            blink_cnt_reg <= 32'd0;
            blink_on_reg  <= 1'b1;
            dhi_reg       <= 7'h00;
            dlo_reg       <= 7'h00;
            run_reg       <= 1'b0;
            xfer_reg      <= 1'b0;
            store_reg     <= 1'b0;
            save_reg      <= 1'b0;
            reload_reg    <= 1'b0;
            off_reg       <= 1'b0;
            led_reg       <= 1'b0;
        end else begin
            blink_cnt_reg <= blink_cnt_next;
            blink_on_reg  <= blink_on_next;
            dhi_reg       <= dhi_next;
            dlo_reg       <= dlo_next;
            run_reg       <= (st_next == ST_RUN);
            xfer_reg      <= (st_next == ST_XFER);
            store_reg     <= (st_next == ST_STORE);
            save_reg      <= (st_next == ST_SAVE);
            reload_reg    <= (st_next == ST_RELOAD);
            off_reg       <= (st_next == ST_OFF);
            led_reg       <= !int_f;
        end
    end

    assign shm_sel_out       = sel_reg;
    assign shm_data_oe_n_out = oe_n_reg;
    assign cpu_reset_out     = creset_reg;
    assign ctrl_run_out      = run_reg;
    assign xfer_mode_out     = xfer_reg;
    assign store_req_out     = store_reg;
    assign save_req_out      = save_reg;
    assign reload_req_out    = reload_reg;
    assign backup_off_out    = off_reg;
    assign digit_hi_out      = dhi_reg;
    assign digit_lo_out      = dlo_reg;
    assign intensity_led_out = led_reg;

endmodule
`default_nettype wire

/* File: testbench/pbpwc_sva.sv */
// Purpose: port checker for the panel and window control block
// Assumes: panel pins pass the filter within six cycles
// Notes:   bound onto every pbpwc_top
`timescale 1ns/1ns
`default_nettype none
module pbpwc_sva (
    // clock and reset
    input wire logic        core_clk_in,
    input wire logic        rst_in,
    // host bus
    input wire logic [19:0] host_addr_in,
    input wire logic        host_memr_n_in,
    input wire logic        host_memw_n_in,
    input wire logic        shm_sel_out,
    input wire logic        shm_data_oe_n_out,
    input wire logic [2:0]  base_sw_in,
    // panel and supply
    input wire logic        intensity_sw_in,
    input wire logic        intensity_led_out,
    input wire logic        reset_key_in,
    input wire logic        cpu_reset_out,
    input wire logic        save_req_out,
    input wire logic        save_done_in,
    input wire logic        backup_off_out,
    input wire logic        reload_req_out,
    input wire logic        backup_supply_unit_fitted_in,
    input wire logic        run_stop_sw_in,
    input wire logic        ctrl_run_out,
    input wire logic        store_req_out,
    input wire logic        xfer_mode_out
);
    // ****************************************
    // idle strobe counter
    // ****************************************
    logic [3:0] idle_cnt_reg;
    logic [3:0] idle_cnt_next;
    always_comb begin
        idle_cnt_next = idle_cnt_reg;
        if (!host_memr_n_in || !host_memw_n_in) begin
            idle_cnt_next = 4'h0;
        end else if (idle_cnt_reg != 4'hF) begin
            idle_cnt_next = idle_cnt_reg + 4'h1;
        end
    end
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            idle_cnt_reg <= 4'h0;
        end else begin
            idle_cnt_reg <= idle_cnt_next;
        end
    end
    // ****************************************
    // properties
    // ****************************************
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (rst_in);
    property p_key; $rose(reset_key_in) |-> ##[1:6] cpu_reset_out; endproperty
    property p_oe; !shm_data_oe_n_out |-> shm_sel_out && host_memw_n_in; endproperty
    property p_win; shm_sel_out |-> host_addr_in[19:13] == 7'h68 + {4'h0, base_sw_in}; endproperty
    property p_idle; idle_cnt_reg >= 4'h8 |-> !shm_sel_out && shm_data_oe_n_out; endproperty
    property p_save; $rose(backup_off_out) |-> $past(save_req_out) && $past(save_done_in); endproperty
    property p_sticky; backup_off_out |=> backup_off_out; endproperty
    property p_led_on; (!intensity_sw_in) [*8] |-> intensity_led_out; endproperty
    property p_led_off; intensity_sw_in [*8] |-> !intensity_led_out; endproperty
    property p_reload; $rose(reload_req_out) |-> $past(backup_supply_unit_fitted_in); endproperty
    property p_run; ctrl_run_out |-> !store_req_out && !xfer_mode_out && !save_req_out; endproperty
    property p_stop; run_stop_sw_in [*8] |-> !ctrl_run_out; endproperty
    a_key: assert property (p_key) else $error("reset key did not reset cpu");
    a_oe: assert property (p_oe) else $error("data driven outside read select");
    a_win: assert property (p_win) else $error("select outside window");
    a_idle: assert property (p_idle) else $error("select without strobe");
    a_save: assert property (p_save) else $error("supply off before save done");
    a_sticky: assert property (p_sticky) else $error("supply switched back on");
    a_led_on: assert property (p_led_on) else $error("led dark at high intensity");
    a_led_off: assert property (p_led_off) else $error("led lit at low intensity");
    a_reload: assert property (p_reload) else $error("reload without backup unit");
    a_run: assert property (p_run) else $error("running during store or transfer");
    a_stop: assert property (p_stop) else $error("running with switch at stop");
    c_store: cover property ($rose(store_req_out));
    c_save: cover property ($rose(backup_off_out));
    c_sel: cover property ($rose(shm_sel_out));
endmodule
bind pbpwc_top pbpwc_sva u_pbpwc_sva (.core_clk_in(core_clk_in), .rst_in(rst_in), .host_addr_in(host_addr_in),
    .host_memr_n_in(host_memr_n_in), .host_memw_n_in(host_memw_n_in), .shm_sel_out(shm_sel_out),
    .shm_data_oe_n_out(shm_data_oe_n_out), .base_sw_in(base_sw_in), .intensity_sw_in(intensity_sw_in),
    .intensity_led_out(intensity_led_out), .reset_key_in(reset_key_in), .cpu_reset_out(cpu_reset_out),
    .save_req_out(save_req_out), .save_done_in(save_done_in), .backup_off_out(backup_off_out),
    .reload_req_out(reload_req_out), .backup_supply_unit_fitted_in(backup_supply_unit_fitted_in),
    .ctrl_run_out(ctrl_run_out), .store_req_out(store_req_out), .xfer_mode_out(xfer_mode_out),
    .run_stop_sw_in(run_stop_sw_in));
`default_nettype wire

/* File: testbench/pbpwc_host_model.sv */
// Purpose: host expansion bus master issuing memory cycles
// Assumes: select answers within ten cycles
// Notes:   idle address lines toggle every cycle
`timescale 1ns/1ns
`default_nettype none
module pbpwc_host_model (
    // clock
    input  wire logic        core_clk_in,
    // answer from the window
    input  wire logic        shm_sel_in,
    input  wire logic        shm_data_oe_n_in,
    // host strobes and address
    output logic      [19:0] host_addr_out,
    output logic             host_memr_n_out = 1'b1,
    output logic             host_memw_n_out = 1'b1
);
    logic [19:0] addr_q = 20'h00000;
    logic        hold_q = 1'b0;
    logic        tgl_q  = 1'b0;
    always @(posedge core_clk_in) tgl_q <= ~tgl_q;
    assign host_addr_out = hold_q ? addr_q : (~addr_q ^ {20{tgl_q}});
    // address held well past the strobe so select can fall
    task automatic access(input logic [19:0] a, input logic wr, output logic hit, output logic drv);
        hit = 1'b0;
        drv = 1'b0;
        @(negedge core_clk_in);
        addr_q = a;
        hold_q = 1'b1;
        host_memr_n_out = wr;
        host_memw_n_out = ~wr;
        for (int i = 0; i < 10 && !hit; i++) begin
            @(posedge core_clk_in);
            hit = (shm_sel_in === 1'b1);
            drv = hit && (shm_data_oe_n_in === 1'b0);
        end
        @(negedge core_clk_in);
        host_memr_n_out = 1'b1;
        host_memw_n_out = 1'b1;
        repeat (10) @(negedge core_clk_in);
        hold_q = 1'b0;
    endtask
endmodule
`default_nettype wire

/* File: testbench/pbpwc_top_tb.sv */
// Purpose: self-checking bench for the panel and window control block
// Assumes: blink half period shortened to four cycles
// Notes:   segments gfedcba, upper digit blank on zero
`timescale 1ns/1ns
`default_nettype none
module pbpwc_top_tb;
    import pbpwc_pkg::*;
    typedef struct packed {logic [19:0] off; logic wr; logic hit;} pbpwc_row_s;
    pbpwc_row_s  rows [4] = '{'{20'h00000, 1'b0, 1'b1}, '{20'h01FFF, 1'b1, 1'b1},
                              '{20'h02000, 1'b0, 1'b0}, '{20'hFFFFF, 1'b1, 1'b0}};
    logic        clk = 1'b0;
    logic        rst, run_sw, boot_sw, key, reload, inten, fitted, pfail, loaded;
    logic        st_done, sv_done, rl_done, err_v, memr_n, memw_n, hit, drv;
    logic [2:0]  base_sw;
    logic [7:0]  err_c;
    logic [19:0] addr;
    logic        sel, oe_n, boff, cpu_rst, run, xfer, st_req, sv_req, rl_req, led;
    logic [6:0]  dhi, dlo;
    int          num_errors = 0;
    int          cmp_count = 0;
    always #4 clk = ~clk;
    pbpwc_top #(.BLINK_CYC(4)) u_pbpwc_top (.core_clk_in(clk), .rst_in(rst), .host_addr_in(addr),
        .host_memr_n_in(memr_n), .host_memw_n_in(memw_n), .shm_sel_out(sel), .shm_data_oe_n_out(oe_n),
        .base_sw_in(base_sw), .run_stop_sw_in(run_sw), .boot_mode_sw_in(boot_sw), .reset_key_in(key),
        .reload_key_in(reload), .intensity_sw_in(inten), .backup_supply_unit_fitted_in(fitted),
        .power_fail_in(pfail), .backup_off_out(boff), .program_loaded_in(loaded), .store_done_in(st_done),
        .save_done_in(sv_done), .reload_done_in(rl_done), .error_valid_in(err_v), .error_code_in(err_c),
        .cpu_reset_out(cpu_rst), .ctrl_run_out(run), .xfer_mode_out(xfer), .store_req_out(st_req),
        .save_req_out(sv_req), .reload_req_out(rl_req), .digit_hi_out(dhi), .digit_lo_out(dlo),
        .intensity_led_out(led));
    pbpwc_host_model u_pbpwc_host_model (.core_clk_in(clk), .shm_sel_in(sel), .shm_data_oe_n_in(oe_n),
        .host_addr_out(addr), .host_memr_n_out(memr_n), .host_memw_n_out(memw_n));
    // ****************************************
    // helpers
    // ****************************************
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic chk(input string n, input logic [19:0] e, input logic [19:0] g);
        cmp_count++;
        if (g !== e) begin
            num_errors++;
            $display("unexpected %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic blink(input logic [6:0] h, input logic [6:0] l);
        logic on, off;
        on = 1'b0;
        off = 1'b0;
        repeat (24) begin
            cyc(1);
            if (dhi === h && dlo === l) on = 1'b1;
            if (dhi === 7'h00 && dlo === 7'h00) off = 1'b1;
        end
        chk("blink_on", 1'b1, on);
        chk("blink_off", 1'b1, off);
    endtask
    task automatic press;
        key = 1'b1;
        cyc(6);
        chk("cpu_reset", 1'b1, cpu_rst);
        key = 1'b0;
        cyc(20);
    endtask
    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    initial begin
        repeat (100000) @(posedge clk);
        num_errors++;
        complete_run();
    end
    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        {base_sw, run_sw, boot_sw, key, reload, inten, pfail, loaded, st_done, sv_done, rl_done, err_v} = '0;
        err_c = 8'h42;
        fitted = 1'b1;
        rst = 1'b1;
        cyc(20);
        chk("cpu_reset", 1'b1, cpu_rst);
        chk("oe_n", 1'b1, oe_n);
        rst = 1'b0;
        cyc(20);
        blink(7'h79, 7'h06);
        chk("led", 1'b1, led);
        inten = 1'b1;
        cyc(8);
        chk("led", 1'b0, led);
        inten = 1'b0;
        for (int s = 0; s < 8; s++) begin
            base_sw = 3'(s);
            cyc(6);
            foreach (rows[i]) begin
                u_pbpwc_host_model.access(20'hD0000 + {4'h0, base_sw, 13'h0000} + rows[i].off, rows[i].wr, hit, drv);
                chk("sel", rows[i].hit, hit);
                chk("drive", rows[i].hit & ~rows[i].wr, drv);
            end
        end
        loaded = 1'b1;
        press();
        chk("run", 1'b1, run);
        chk("digit_hi", 7'h00, dhi);
        chk("digit_lo", 7'h06, dlo);
        run_sw = 1'b1;
        cyc(8);
        chk("run", 1'b0, run);
        chk("digit_lo", 7'h3F, dlo);
        run_sw = 1'b0;
        cyc(8);
        err_v = 1'b1;
        blink(7'h66, 7'h5B);
        err_v = 1'b0;
        fitted = 1'b0;
        reload = 1'b1;
        cyc(8);
        chk("reload_req", 1'b0, rl_req);
        reload = 1'b0;
        cyc(8);
        fitted = 1'b1;
        reload = 1'b1;
        for (int i = 0; i < 30 && rl_req !== 1'b1; i++) cyc(1);
        chk("reload_req", 1'b1, rl_req);
        reload = 1'b0;
        rl_done = 1'b1;
        cyc(1);
        rl_done = 1'b0;
        cyc(2);
        chk("reload_req", 1'b0, rl_req);
        boot_sw = 1'b1;
        for (int i = 0; i < 30 && st_req !== 1'b1; i++) cyc(1);
        chk("store_req", 1'b1, st_req);
        blink(7'h7F, 7'h3F);
        st_done = 1'b1;
        cyc(1);
        st_done = 1'b0;
        cyc(12);
        chk("store_req", 1'b0, st_req);
        chk("digit_hi", 7'h00, dhi);
        chk("digit_lo", 7'h3F, dlo);
        chk("run", 1'b0, run);
        press();
        chk("xfer", 1'b1, xfer);
        boot_sw = 1'b0;
        cyc(10);
        chk("xfer", 1'b1, xfer);
        press();
        chk("xfer", 1'b0, xfer);
        chk("run", 1'b1, run);
        pfail = 1'b1;
        for (int i = 0; i < 30 && sv_req !== 1'b1; i++) cyc(1);
        chk("save_req", 1'b1, sv_req);
        cyc(5);
        chk("backup_off", 1'b0, boff);
        sv_done = 1'b1;
        cyc(1);
        sv_done = 1'b0;
        pfail = 1'b0;
        cyc(8);
        chk("backup_off", 1'b1, boff);
        chk("save_req", 1'b0, sv_req);
        complete_run();
    end
endmodule
`default_nettype wire
